// ---- core/pcpc_top.sv ----
// Pin level control of the highway port and the configurable subscriber port
`timescale 1ns/1ps
`default_nettype none
`include "pcpc_defs.svh"

module pcpc_top #(
  parameter int HWY_LINES  = `PCPC_HWY_LINES,
  parameter int HWY_SLOTS  = `PCPC_HWY_SLOTS,
  parameter int SLOT_BITS  = `PCPC_SLOT_BITS,
  parameter int SUB_LINES  = `PCPC_SUB_LINES,
  parameter int SUB_FRAME  = `PCPC_SUB_FRAME_BITS,
  parameter int SUB_DIV    = `PCPC_SUB_CLK_DIV
) (
  // System clock and reset
  input  wire logic                          I_CLOCK,
  input  wire logic                          I_RST_N,
  // Highway link clock and frame sync
  input  wire logic                          I_HIGHWAY_BIT_CLOCK,
  input  wire logic                          i_HWY_FRAME_SYNC,
  // Highway configuration
  input  wire logic                          i_HIGHWAY_OUTPUT_ENABLE,
  input  wire logic                          i_HWY_DOUBLE_RATE,
  // Highway pins
  input  wire logic [HWY_LINES-1:0]          i_HIGHWAY_RX_LINE,
  output logic      [HWY_LINES-1:0]          o_HIGHWAY_TX_LINE,
  output logic      [HWY_LINES-1:0]          o_HIGHWAY_TX_OE,
  output logic      [HWY_LINES-1:0]          o_DRIVER_CTRL_OUT,
  // Downstream memory write port, link clock
  output logic                               o_DS_WR_EN,
  output logic      [$clog2(HWY_SLOTS)-1:0]  o_DS_WR_SLOT,
  output logic      [HWY_LINES*SLOT_BITS-1:0] o_DS_WR_DATA,
  // Upstream and tristate memory read port, link clock
  output logic      [$clog2(HWY_SLOTS)-1:0]  o_UP_RD_SLOT,
  input  wire logic [HWY_LINES*SLOT_BITS-1:0] i_UP_DATA,
  input  wire logic [HWY_LINES-1:0]          i_UP_TRISTATE,
  // Subscriber configuration
  input  wire pcpc_pkg::pcpc_mode_t          i_SUB_MODE,
  input  wire logic                          i_SUB_CLOCK_MASTER,
  input  wire logic                          i_SUB_FRAME_SYNC_OUTPUT,
  input  wire logic                          i_SUB_DOUBLE_RATE,
  input  wire logic                          i_SUB_OUTPUT_DRIVE_SELECT,
  input  wire logic                          i_SUB_STANDBY_RELEASE,
  // Subscriber clock and frame sync pins
  input  wire logic                          i_SUB_BIT_CLOCK_I,
  output logic                               o_SUB_BIT_CLOCK_O,
  output logic                               o_SUB_BIT_CLOCK_OE,
  input  wire logic                          i_SUB_FRAME_SYNC_I,
  output logic                               o_SUB_FRAME_SYNC_O,
  output logic                               o_SUB_FRAME_SYNC_OE,
  // Subscriber serial lines
  input  wire logic [SUB_LINES-1:0]          i_SUB_SERIAL_PORT_LINE_I,
  output logic      [SUB_LINES-1:0]          o_SUB_SERIAL_PORT_LINE_O,
  output logic      [SUB_LINES-1:0]          o_SUB_SERIAL_PORT_LINE_OE,
  // Subscriber switching memory side
  output logic      [$clog2(SUB_FRAME)-1:0]  o_SUB_BIT_POS,
  input  wire logic [SUB_LINES-1:0]          i_SUB_TX_BIT,
  input  wire logic [SUB_LINES-1:0]          i_SUB_ASSIGNED,
  output logic      [SUB_LINES-1:0]          o_SUB_RX_BITS,
  output logic                               o_SUB_BIT_STROBE
);

  localparam int SW = $clog2(HWY_SLOTS);   // Slot counter width
  localparam int BW = $clog2(SLOT_BITS);   // Bit counter width
  localparam int FW = $clog2(SUB_FRAME);   // Sub position width
  localparam int DW = $clog2(SUB_DIV);     // Divider width
  localparam int HL = HWY_LINES * SLOT_BITS;

  // Link domain state
  typedef struct packed {
    logic           rst_s1;   // Reset synchroniser
    logic           rst_s2;
    logic           psb_s1;   // Output enable synchroniser
    logic           psb_s2;
    logic           dbl_s1;   // Double rate synchroniser
    logic           dbl_s2;
    logic           phase;    // Odd edge of a double rate clock
    logic [BW-1:0]  bit_cnt;  // Next bit in slot
    logic [SW-1:0]  slot;     // Next slot
    logic           fs_q;     // Registered frame sync
    logic [HWY_LINES-1:0] rx_q;
    logic [HL-1:0]  rx_sh;    // Receive shifters
    logic [HL-1:0]  tx_sh;    // Transmit shifters
    logic [HWY_LINES-1:0] tx_oe;
    logic           wr_en;
    logic [SW-1:0]  wr_slot;
    logic [HL-1:0]  wr_data;
  } pcpc_hwy_t;

  // System domain state
  typedef struct packed {
    logic           clk_s1;   // Sub clock synchroniser
    logic           clk_s2;
    logic           fs_s1;    // Sub frame sync synchroniser
    logic           fs_s2;
    logic [SUB_LINES-1:0] ln_s1;
    logic [SUB_LINES-1:0] ln_s2;
    logic           eff_d;    // Previous effective clock
    logic           half;     // Double rate phase
    logic [DW-1:0]  div;      // Clock divider
    logic           clk_gen;  // Generated sub clock
    logic           fs_gen;   // Generated frame sync
    logic           clk_oe;
    logic           fs_oe;
    logic           dir;      // Previous direction level
    logic [FW-1:0]  bit_cnt;  // Next sub bit position
    logic [SUB_LINES-1:0] line_bit;
    logic [SUB_LINES-1:0] line_act;
    logic [SUB_LINES-1:0] line_o;
    logic [SUB_LINES-1:0] line_oe;
    logic [SUB_LINES-1:0] rx_bits;
    logic           strobe;
  } pcpc_sub_t;

  pcpc_hwy_t       hwy;        // Link state
  pcpc_hwy_t       next_hwy;
  pcpc_sub_t       sub;        // System state
  pcpc_sub_t       next_sub;
  logic            tick;       // Link edge that moves one bit
  logic [BW-1:0]   cur_bit;    // Bit handled at this tick
  logic [SW-1:0]   cur_slot;   // Slot handled at this tick
  logic            iom;
  logic            sld;
  logic            master;
  logic            sdbl;
  logic            fs_out;
  logic            eff;
  logic            act;
  logic            start;
  logic [FW-1:0]   pos;
  logic [SUB_LINES-1:0] mask;

  // Bit timing on the link clock
  always_comb begin
    tick     = !hwy.dbl_s2 || hwy.phase;
    cur_bit  = hwy.fs_q ? '0 : hwy.bit_cnt;
    cur_slot = hwy.fs_q ? '0 : hwy.slot;
  end

  // Highway next state
  always_comb begin
    next_hwy        = hwy;
    next_hwy.rst_s1 = I_RST_N;
    next_hwy.rst_s2 = hwy.rst_s1;
    next_hwy.psb_s1 = i_HIGHWAY_OUTPUT_ENABLE;
    next_hwy.psb_s2 = hwy.psb_s1;
    next_hwy.dbl_s1 = i_HWY_DOUBLE_RATE;
    next_hwy.dbl_s2 = hwy.dbl_s1;
    next_hwy.fs_q   = i_HWY_FRAME_SYNC;
    next_hwy.rx_q   = i_HIGHWAY_RX_LINE;
    next_hwy.phase  = hwy.dbl_s2 && !hwy.phase;
    next_hwy.wr_en  = 1'b0;
    // Disabled highway drops every driver at once
    next_hwy.tx_oe  = hwy.tx_oe & {HWY_LINES{hwy.psb_s2}};
    if (tick) begin
      for (int i = 0; i < HWY_LINES; i++) begin
        next_hwy.rx_sh[i*SLOT_BITS +: SLOT_BITS] =
          {hwy.rx_sh[i*SLOT_BITS +: SLOT_BITS-1], hwy.rx_q[i]};
        next_hwy.tx_sh[i*SLOT_BITS +: SLOT_BITS] =
          {hwy.tx_sh[i*SLOT_BITS +: SLOT_BITS-1], 1'b0};
      end
      // Slot boundary: load data and tristate together
      if (cur_bit == '0) begin
        next_hwy.tx_sh = i_UP_DATA;
        next_hwy.tx_oe = ~i_UP_TRISTATE & {HWY_LINES{hwy.psb_s2}};
      end
      // Last bit: hand the slot to the downstream memory
      if (cur_bit == BW'(SLOT_BITS-1)) begin
        next_hwy.wr_en   = 1'b1;
        next_hwy.wr_slot = cur_slot;
        next_hwy.wr_data = next_hwy.rx_sh;
        next_hwy.slot    = SW'(cur_slot + 1'b1);
        next_hwy.bit_cnt = '0;
      end else begin
        next_hwy.slot    = cur_slot;
        next_hwy.bit_cnt = BW'(cur_bit + 1'b1);
      end
    end
    // Reset held on the link clock
    if (!hwy.rst_s2) begin
      next_hwy        = '0;
      next_hwy.rst_s1 = I_RST_N;
      next_hwy.rst_s2 = hwy.rst_s1;
    end
  end

  // Link register
  always_ff @(posedge I_HIGHWAY_BIT_CLOCK) begin
    hwy <= next_hwy;
  end

  // Highway outputs, one per line
  for (genvar g = 0; g < HWY_LINES; g++) begin : g_tx
    assign o_HIGHWAY_TX_LINE[g] = hwy.tx_sh[g*SLOT_BITS+SLOT_BITS-1];
  end
  assign o_HIGHWAY_TX_OE   = hwy.tx_oe;
  // Drivers held off while the reset pin is low
  assign o_DRIVER_CTRL_OUT = ~hwy.tx_oe | {HWY_LINES{~I_RST_N}};
  assign o_DS_WR_EN        = hwy.wr_en;
  assign o_DS_WR_SLOT      = hwy.wr_slot;
  assign o_DS_WR_DATA      = hwy.wr_data;
  assign o_UP_RD_SLOT      = hwy.slot;

  // Subscriber style decoding
  always_comb begin
    iom    = i_SUB_MODE == pcpc_pkg::PCPC_MODE_IOM;
    sld    = i_SUB_MODE == pcpc_pkg::PCPC_MODE_SLD;
    master = iom && i_SUB_CLOCK_MASTER;
    sdbl   = iom && i_SUB_DOUBLE_RATE;
    fs_out = iom && i_SUB_FRAME_SYNC_OUTPUT;
    eff    = master ? sub.clk_gen : sub.clk_s2;
    act    = eff && !sub.eff_d && (!sdbl || sub.half);
    // SLD frame starts when direction turns to send
    start  = sld ? (sub.fs_s2 && !sub.dir) : (fs_out ? 1'b0 : sub.fs_s2);
    pos    = start ? '0 : sub.bit_cnt;
    // SLD drives all ports while sending and none while listening; other styles only downstream
    mask   = sld ? {SUB_LINES{sub.fs_s2}}
                 : {{(SUB_LINES/2){1'b0}}, {(SUB_LINES/2){1'b1}}};
  end

  // Subscriber next state
  always_comb begin
    next_sub        = sub;
    next_sub.clk_s1 = i_SUB_BIT_CLOCK_I;
    next_sub.clk_s2 = sub.clk_s1;
    next_sub.fs_s1  = i_SUB_FRAME_SYNC_I;
    next_sub.fs_s2  = sub.fs_s1;
    next_sub.ln_s1  = i_SUB_SERIAL_PORT_LINE_I;
    next_sub.ln_s2  = sub.ln_s1;
    next_sub.eff_d  = eff;
    next_sub.clk_oe = master;
    next_sub.fs_oe  = fs_out;
    next_sub.fs_gen = fs_out && (sub.bit_cnt == '0);
    next_sub.strobe = 1'b0;
    // Clock divider for the master clock
    if (!master) begin
      next_sub.div     = '0;
      next_sub.clk_gen = 1'b0;
    end else if (sub.div == DW'(SUB_DIV-1)) begin
      next_sub.div     = '0;
      next_sub.clk_gen = !sub.clk_gen;
    end else begin
      next_sub.div     = DW'(sub.div + 1'b1);
    end
    // Double rate phase
    if (eff && !sub.eff_d) begin
      next_sub.half = sdbl && !sub.half;
    end
    // One bit position
    if (act) begin
      next_sub.bit_cnt  = FW'(pos + 1'b1);
      next_sub.dir      = sub.fs_s2;
      next_sub.rx_bits  = sub.ln_s2;
      next_sub.strobe   = 1'b1;
      next_sub.line_bit = i_SUB_TX_BIT;
      next_sub.line_act = i_SUB_ASSIGNED & mask;
    end
    // Pin drive, released at once by standby
    next_sub.line_o  = i_SUB_OUTPUT_DRIVE_SELECT ? '0 : sub.line_bit;
    next_sub.line_oe = sub.line_act & {SUB_LINES{i_SUB_STANDBY_RELEASE}}
                     & (i_SUB_OUTPUT_DRIVE_SELECT ? ~sub.line_bit : '1);
    if (!I_RST_N) begin
      next_sub = '0;
    end
  end

  // System register
  always_ff @(posedge I_CLOCK) begin
    sub <= next_sub;
  end

  // Subscriber outputs
  assign o_SUB_BIT_CLOCK_O         = sub.clk_gen;
  assign o_SUB_BIT_CLOCK_OE        = sub.clk_oe;
  assign o_SUB_FRAME_SYNC_O        = sub.fs_gen;
  assign o_SUB_FRAME_SYNC_OE       = sub.fs_oe;
  assign o_SUB_SERIAL_PORT_LINE_O  = sub.line_o;
  assign o_SUB_SERIAL_PORT_LINE_OE = sub.line_oe;
  assign o_SUB_BIT_POS             = sub.bit_cnt;
  assign o_SUB_RX_BITS             = sub.rx_bits;
  assign o_SUB_BIT_STROBE          = sub.strobe;

  // Link side checks
  sequence byte_end_s;
    tick && cur_bit == BW'(SLOT_BITS-1);
  endsequence
  sequence tx_load_s;
    tick && cur_bit == '0 && hwy.psb_s2;
  endsequence

  psb_off_a: assert property (@(posedge I_HIGHWAY_BIT_CLOCK) disable iff (!hwy.rst_s2)
    !hwy.psb_s2 |=> o_HIGHWAY_TX_OE == '0)
    else $error("highway driven while disabled");
  tri_slot_a: assert property (@(posedge I_HIGHWAY_BIT_CLOCK) disable iff (!hwy.rst_s2)
    tx_load_s |=> o_HIGHWAY_TX_OE == ~$past(i_UP_TRISTATE))
    else $error("tristate slot not honoured");
  drv_ctrl_a: assert property (@(posedge I_HIGHWAY_BIT_CLOCK) disable iff (!hwy.rst_s2)
    I_RST_N |-> o_DRIVER_CTRL_OUT == ~o_HIGHWAY_TX_OE)
    else $error("driver control disagrees with tx");
  rx_write_a: assert property (@(posedge I_HIGHWAY_BIT_CLOCK) disable iff (!hwy.rst_s2)
    byte_end_s |=> o_DS_WR_EN && o_DS_WR_SLOT == $past(cur_slot) ##1 !o_DS_WR_EN)
    else $error("slot write missing");
  dbl_rate_a: assert property (@(posedge I_HIGHWAY_BIT_CLOCK) disable iff (!hwy.rst_s2)
    (hwy.dbl_s2 && $past(hwy.dbl_s2) && tick) ##1 hwy.dbl_s2 |-> !tick ##1 tick)
    else $error("double rate not halved");

  // Driver reset and subscriber side checks
  drv_reset_a: assert property (@(posedge I_CLOCK)
    !I_RST_N |-> o_DRIVER_CTRL_OUT == '1)
    else $error("driver control low in reset");
  sub_standby_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !i_SUB_STANDBY_RELEASE |=> o_SUB_SERIAL_PORT_LINE_OE == '0)
    else $error("sub lines driven in standby");
  open_drain_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    i_SUB_OUTPUT_DRIVE_SELECT |=> o_SUB_SERIAL_PORT_LINE_O == '0)
    else $error("open drain line driven high");
  sld_clock_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    i_SUB_MODE == pcpc_pkg::PCPC_MODE_SLD |=> !o_SUB_BIT_CLOCK_OE)
    else $error("clock driven in SLD style");
  sld_fsync_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    i_SUB_MODE == pcpc_pkg::PCPC_MODE_SLD |=> !o_SUB_FRAME_SYNC_OE)
    else $error("frame sync driven in SLD style");

endmodule
`default_nettype wire

// ---- shared/pcpc_defs.svh ----
// Constants for the highway and subscriber pin control block
`ifndef PCPC_DEFS_SVH
`define PCPC_DEFS_SVH
// Highway transmit and receive lines
`define PCPC_HWY_LINES 4
// Time slots in one highway frame
`define PCPC_HWY_SLOTS 32
// Bits in one time slot or channel
`define PCPC_SLOT_BITS 8
// Subscriber lines: low half downstream, high half upstream
`define PCPC_SUB_LINES 8
// Bit positions in one subscriber frame
`define PCPC_SUB_FRAME_BITS 256
// System clocks per half period of a generated subscriber clock
`define PCPC_SUB_CLK_DIV 6
`endif

// ---- shared/pcpc_pkg.sv ----
// Types shared by the highway and subscriber pin control block
package pcpc_pkg;
  // Subscriber interface style
  typedef enum logic [1:0] {PCPC_MODE_IOM, PCPC_MODE_SLD, PCPC_MODE_PCM} pcpc_mode_t;
endpackage

// ---- tb/pcm_configurable_sub_interface_port_pin_control_tb_top.sv ----
// Self-checking bench for the highway and subscriber pin control block
`timescale 1ns/1ps
`default_nettype none
module pcm_configurable_sub_interface_port_pin_control_tb_top;
  logic clk, rst_n, lclk, hwy_en, hwy_dbl, fs, sub_clk_tb;
  logic [5:0] cfg;  // Master, sync out, double, open drain, standby release, sync in
  pcpc_pkg::pcpc_mode_t mode;
  logic [7:0] asg, ln_o, ln_oe, bit_pos, rx_bits;
  logic [3:0] rx, tx, tx_oe, drv, up_tri;
  logic [31:0] up_data, ds_data;
  logic [4:0] ds_slot, rd_slot;
  logic [2:0] div = 3'h0;
  logic ds_en, ck_o, ck_oe, fs_o, fs_oe, strobe;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;

  pcpc_top DUT (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_HIGHWAY_BIT_CLOCK(lclk), .i_HWY_FRAME_SYNC(fs),
    .i_HIGHWAY_OUTPUT_ENABLE(hwy_en), .i_HWY_DOUBLE_RATE(hwy_dbl),
    .i_HIGHWAY_RX_LINE(rx), .o_HIGHWAY_TX_LINE(tx), .o_HIGHWAY_TX_OE(tx_oe),
    .o_DRIVER_CTRL_OUT(drv), .o_DS_WR_EN(ds_en), .o_DS_WR_SLOT(ds_slot),
    .o_DS_WR_DATA(ds_data), .o_UP_RD_SLOT(rd_slot), .i_UP_DATA(up_data),
    .i_UP_TRISTATE(up_tri), .i_SUB_MODE(mode), .i_SUB_CLOCK_MASTER(cfg[5]),
    .i_SUB_FRAME_SYNC_OUTPUT(cfg[4]), .i_SUB_DOUBLE_RATE(cfg[3]),
    .i_SUB_OUTPUT_DRIVE_SELECT(cfg[2]), .i_SUB_STANDBY_RELEASE(cfg[1]),
    .i_SUB_BIT_CLOCK_I(ck_oe ? ck_o : sub_clk_tb), .o_SUB_BIT_CLOCK_O(ck_o),
    .o_SUB_BIT_CLOCK_OE(ck_oe), .i_SUB_FRAME_SYNC_I(fs_oe ? fs_o : cfg[0]),
    .o_SUB_FRAME_SYNC_O(fs_o), .o_SUB_FRAME_SYNC_OE(fs_oe),
    .i_SUB_SERIAL_PORT_LINE_I(~ln_oe | ln_o), .o_SUB_SERIAL_PORT_LINE_O(ln_o),
    .o_SUB_SERIAL_PORT_LINE_OE(ln_oe), .o_SUB_BIT_POS(bit_pos), .i_SUB_TX_BIT(8'hA5),
    .i_SUB_ASSIGNED(asg), .o_SUB_RX_BITS(rx_bits), .o_SUB_BIT_STROBE(strobe)
  );

  pcpc_far_model FAR (
    .i_clk(lclk), .i_double(hwy_dbl), .i_rd_slot(rd_slot), .o_frame_sync(fs),
    .o_rx(rx), .o_up_data(up_data), .o_up_tri(up_tri)
  );

  // System clock 20 ns, link clock 6 ns with unrelated phase
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3.7;
    forever #3 lclk = ~lclk;
  end
  // Slave subscriber clock, one half period per 8 system cycles
  always @(negedge clk) begin
    div <= div + 3'h1;
    if (div == 3'h7) sub_clk_tb <= ~sub_clk_tb;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reset mid-run: controls forced at once, every output quiet
  task automatic reset_mid(input string name);
    @(negedge clk);
    rst_n = 1'b0;
    #1;
    check("driver ctrl in reset", drv, 4'hF);
    repeat (6) @(negedge clk);
    check("driver ctrl held", drv, 4'hF);
    check("tx enables in reset", tx_oe, 4'h0);
    check("sub enables in reset", {ln_oe, ck_oe, fs_oe}, 10'h000);
    check("write strobe in reset", ds_en, 1'b0);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    $display("test %s done", name);
  endtask

  // One highway frame: receive writes, tristate bits and driver controls
  task automatic hwy_win(input string name, input logic en, input logic dbl);
    int m, nw, nz, n1, nb, e1, nd;
    logic [4:0] prev;
    @(negedge clk);
    hwy_en = en;
    hwy_dbl = dbl;
    m = dbl ? 2 : 1;
    {nw, nz, n1, nb, e1, nd} = '0;
    for (int s = 0; s < 32; s++) if (s % 4 != 0) e1 += $countones(s[4:0]) * m;
    repeat (600 * m) @(negedge lclk);
    repeat (256 * m) begin
      @(negedge lclk);
      nz += 4 - $countones(tx_oe);
      n1 += int'(tx_oe[0] & tx[0]);
      nd += $countones(drv);
      if (drv !== ~tx_oe) nb++;
      if ($isunknown({tx, tx_oe, drv})) nb++;
      if (ds_en === 1'b1) begin
        if (ds_data !== {ds_slot, 3'h7, ds_slot, 3'h5, ds_slot, 3'h3, ds_slot, 3'h1}) nb++;
        if (nw > 0 && ds_slot !== prev + 5'h01) nb++;
        prev = ds_slot;
        nw++;
      end
    end
    check("highway writes", nw, 32);
    check("tx off bits", nz, en ? 256 * m : 1024 * m);
    check("driver ctrl high bits", nd, en ? 256 * m : 1024 * m);
    check("tx one bits", n1, en ? e1 : 0);
    check("highway faults", nb, 0);
    $display("test %s done", name);
  endtask

  // Wait for a subscriber bit, bounded
  task automatic wait_strobe();
    int n;
    n = 0;
    while (strobe !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) check("sub strobe", 0, 1);
    @(negedge clk);
  endtask

  // One subscriber configuration and the pin drive it gives
  task automatic sub_case(input string name, input pcpc_pkg::pcpc_mode_t md,
                          input logic [5:0] c, input logic [7:0] a, input logic [7:0] e_oe,
                          input logic [7:0] msk, input logic [7:0] e_o, input logic [1:0] e_ck);
    int p, nc;
    logic ck_prev;
    @(negedge clk);
    mode = md;
    cfg = c;
    asg = a;
    repeat (2) wait_strobe();
    repeat (3) @(negedge clk);
    check("sub line enables", ln_oe, e_oe);
    check("sub line levels", ln_o & msk, e_o);
    check("sub clock and sync enables", {ck_oe, fs_oe}, e_ck);
    // A generated clock toggles every 6 system cycles: 8 changes in 48
    nc = 0;
    ck_prev = ck_o;
    repeat (48) begin
      @(negedge clk);
      nc += int'(ck_o !== ck_prev);
      ck_prev = ck_o;
    end
    check("sub clock toggles", nc, (md == pcpc_pkg::PCPC_MODE_IOM && c[5]) ? 8 : 0);
    // Position moves by one per bit; received bits echo the pin levels
    wait_strobe();
    p = int'(bit_pos);
    wait_strobe();
    check("sub bit position", bit_pos, 8'(p + 1));
    check("sub rx bits", rx_bits, 8'(~e_oe | (c[2] ? 8'h00 : 8'hA5)));
    $display("test %s done", name);
  endtask

  initial begin
    {rst_n, hwy_dbl, sub_clk_tb, cfg, asg} = '0;
    hwy_en = 1'b1;
    mode = pcpc_pkg::PCPC_MODE_IOM;
    reset_mid("power up reset");
    hwy_win("highway single", 1'b1, 1'b0);
    hwy_win("highway double", 1'b1, 1'b1);
    hwy_win("highway disabled", 1'b0, 1'b0);
    hwy_win("highway enabled again", 1'b1, 1'b0);
    sub_case("iom master", pcpc_pkg::PCPC_MODE_IOM, 6'h32, 8'hFF, 8'h0F, 8'h0F, 8'h05, 2'h3);
    sub_case("iom open drain", pcpc_pkg::PCPC_MODE_IOM, 6'h2E, 8'hFF, 8'h0A, 8'h0F, 8'h00, 2'h2);
    sub_case("standby", pcpc_pkg::PCPC_MODE_IOM, 6'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 2'h0);
    sub_case("unassigned", pcpc_pkg::PCPC_MODE_IOM, 6'h02, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0);
    sub_case("ports 0 and 1", pcpc_pkg::PCPC_MODE_IOM, 6'h02, 8'h33, 8'h03, 8'h0F, 8'h05, 2'h0);
    sub_case("sld drive", pcpc_pkg::PCPC_MODE_SLD, 6'h3B, 8'hFF, 8'hFF, 8'hFF, 8'hA5, 2'h0);
    sub_case("sld listen", pcpc_pkg::PCPC_MODE_SLD, 6'h02, 8'hFF, 8'h00, 8'h00, 8'h00, 2'h0);
    sub_case("pcm style", pcpc_pkg::PCPC_MODE_PCM, 6'h02, 8'hFF, 8'h0F, 8'h0F, 8'h05, 2'h0);
    reset_mid("reset mid run");
    hwy_win("highway after reset", 1'b1, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- tb/pcpc_far_model.sv ----
// Far side of the highway: frame timing, receive bits and memory read answers
`timescale 1ns/1ps
`default_nettype none
module pcpc_far_model (
  // Link clock and rate
  input  wire logic        i_clk,
  input  wire logic        i_double,
  // Slot that the block reads next
  input  wire logic [4:0]  i_rd_slot,
  // Highway side outputs
  output logic             o_frame_sync,
  output logic [3:0]       o_rx,
  output logic [31:0]      o_up_data,
  output logic [3:0]       o_up_tri
);
  logic [8:0] cnt;  // Free running link cycle count
  logic [7:0] pos;  // Bit position in the frame
  logic [7:0] rxb;  // Receive byte of the current slot
  initial cnt = 9'h000;
  // Lines change just after each rising link edge
  always @(posedge i_clk) cnt <= cnt + 9'h001;
  // A bit lasts two link cycles at double rate
  always_comb begin
    pos = i_double ? cnt[8:1] : cnt[7:0];
    o_frame_sync = (pos == 8'h00);
    for (int i = 0; i < 4; i++) begin
      rxb = {pos[7:3], 2'(i), 1'b1};
      o_rx[i] = rxb[3'h7 - pos[2:0]];
      o_up_data[8*i +: 8] = {i_rd_slot, 3'(i)};
      o_up_tri[i] = (i_rd_slot[1:0] == 2'(i));
    end
  end
endmodule
`default_nettype wire
